// [rtl/gdfd_pkg.sv]
// Constants, carriers and states shared by the gate driver fault bank
package gdfd_pkg;

   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam logic [3:0] ADDR_GLOBAL = 4'h0;
   localparam logic [3:0] ADDR_PHASE1 = 4'h1;
   localparam logic [3:0] ADDR_PHASE2 = 4'h2;
   localparam logic [3:0] ADDR_PHASE3 = 4'h3;
   localparam logic [3:0] ADDR_TEST_CTRL = 4'h5;

   // Global fault flag positions
   localparam int GLB_SUMMARY = 7;
   localparam int GLB_OPEN_OR_SHORT = 0;
   localparam logic [7:0] RESET_FLAGS = 8'h00;

   // Phase diagnostic positions
   localparam int PH_GROUND_SHORT = 6;
   localparam int PH_OPEN_LOAD = 4;

   // Test control positions
   localparam int CTRL_OPEN_LOAD = 0;
   localparam int CTRL_SHORT = 1;
   localparam int CTRL_CLEAR = 7;

   // ----------------------------------------------------------------
   // Serial frame
   // ----------------------------------------------------------------
   localparam logic [4:0] FRAME_LAST_BIT = 5'h0F;
   localparam logic [4:0] HEADER_LAST_BIT = 5'h07;
   localparam logic [4:0] HEADER_BITS = 5'h08;
   localparam logic [4:0] FRAME_BITS = 5'h10;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 10;
   localparam int TEST_TIME_NS = 1000;
   localparam int TEST_CYCLES = (TEST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SUPPLY_LOW_MV = 6000;

   // ----------------------------------------------------------------
   // Carriers and states
   // ----------------------------------------------------------------
   typedef struct packed {
      logic gate_drive;
      logic charge_pump_low;
      logic supply_undervoltage;
      logic overcurrent;
      logic overtemp_warning;
      logic overtemp_shutdown;
   } gdfd_global_s;

   typedef struct packed {
      logic sense_overcurrent;
      logic at_ground;
      logic at_battery;
      logic load_open;
      logic low_gate_source;
      logic high_gate_source;
      logic low_drain_source;
      logic high_drain_source;
   } gdfd_phase_s;

   typedef enum logic [1:0] {
      TEST_IDLE,
      TEST_OPEN_LOAD,
      TEST_SHORT
   } gdfd_test_e;

endpackage : gdfd_pkg

// [rtl/gdfd_fault_bank.sv]
// Fault and diagnostic register bank with serial register port and load tests

// Function
// - Global fault register at 0x00: summary, gate, pump, supply, current, thermal, open/short.
// - Three phase diagnostic registers at 0x01 to 0x03 with the eight listed fault bits.
// - Any fault sets its named status bit and asserts the fault indication.
// - Writing 1 to open-load trigger at 0x05 starts the passive open-load check.
// - Open load found sets phase open bit, open/short summary, fault indication.
// - Writing 1 to short trigger at 0x05 starts the battery/ground short check.
// - Ground short found sets phase ground bit, open/short summary, fault indication.
// - Battery short found sets phase battery bit, open/short summary, fault indication.
// - Gate, current, supply and thermal faults readable; undervoltage is latched from the supply_undervoltage input.
module gdfd_fault_bank #(
   parameter int NUM_PHASES = 3,
   parameter int TEST_CYCLES = gdfd_pkg::TEST_CYCLES
) (
   input wire logic i_mclk,
   input wire logic i_rst_n,
   input wire logic i_spi_cs_n,
   input wire logic i_spi_sclk,
   input wire logic i_spi_mosi,
   output logic o_spi_miso,
   output logic o_spi_miso_oe_n,
   input wire gdfd_pkg::gdfd_global_s i_global_cond,
   input wire gdfd_pkg::gdfd_phase_s i_phase_cond [NUM_PHASES],
   output logic o_open_load_test_active,
   output logic o_short_test_active,
   output logic o_fault_indication_n
);

   // ----------------------------------------------------------------
   // Parameter checks
   // ----------------------------------------------------------------
   if (NUM_PHASES < 1 || NUM_PHASES > 3) begin : g_bad_phases
      $error("NUM_PHASES must lie between 1 and 3");
   end
   if (TEST_CYCLES < 1 || TEST_CYCLES > 65535) begin : g_bad_test
      $error("TEST_CYCLES must lie between 1 and 65535");
   end
   if (gdfd_pkg::HEADER_BITS != 5'h08) begin : g_bad_header
      $error("Header must carry exactly one status byte");
   end
   if (gdfd_pkg::FRAME_BITS != gdfd_pkg::HEADER_BITS + gdfd_pkg::HEADER_BITS) begin : g_bad_frame
      $error("Frame must be twice the header length");
   end
   if (gdfd_pkg::FRAME_LAST_BIT != gdfd_pkg::FRAME_BITS - 5'h01) begin : g_bad_frame_last
      $error("Last frame bit must be one below the frame length");
   end
   if (gdfd_pkg::HEADER_LAST_BIT != gdfd_pkg::HEADER_BITS - 5'h01) begin : g_bad_header_last
      $error("Last header bit must be one below the header length");
   end
   if (int'(gdfd_pkg::ADDR_PHASE1) + NUM_PHASES > int'(gdfd_pkg::ADDR_TEST_CTRL)
      || gdfd_pkg::ADDR_PHASE1 == gdfd_pkg::ADDR_GLOBAL) begin : g_bad_map
      $error("Phase registers must sit between the global and control registers");
   end
   if (gdfd_pkg::PH_GROUND_SHORT != gdfd_pkg::PH_OPEN_LOAD + 2) begin : g_bad_phase_bits
      $error("Open and short bits must be three adjacent positions");
   end
   if (gdfd_pkg::GLB_SUMMARY != 7 || gdfd_pkg::GLB_OPEN_OR_SHORT != 0) begin : g_bad_global_bits
      $error("Summary bits must bound the global register");
   end

   localparam logic [15:0] TEST_LOAD = 16'(TEST_CYCLES - 1);

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   logic sclk_q;
   logic cs_q;
   logic sclk_rise;
   logic sclk_fall;
   logic cs_fall;
   logic [4:0] bit_cnt;
   logic [15:0] rx_shift;
   logic [15:0] next_rx;
   logic [7:0] status_cap;
   logic [7:0] read_cap;
   logic frame_write;
   logic open_load_test_trigger;
   logic short_test_trigger;
   logic clear_faults;
   logic open_pend;
   logic short_pend;
   gdfd_pkg::gdfd_test_e test_state;
   logic [15:0] test_timer;
   logic timer_done;
   logic test_start;
   logic open_done;
   logic short_done;
   logic [5:0] live_flags;
   logic [5:0] live_set;
   logic [7:0] diag [NUM_PHASES];
   logic [NUM_PHASES-1:0] phase_open_short;
   logic [NUM_PHASES-1:0] phase_any;
   logic open_or_short_summary_flag;
   logic fault_summary;
   logic [7:0] global_fault_flags;

   // ----------------------------------------------------------------
   // Test state decoding
   // ----------------------------------------------------------------
   function automatic logic in_test(input gdfd_pkg::gdfd_test_e state,
      input gdfd_pkg::gdfd_test_e kind);
      return state == kind;
   endfunction : in_test

   // ----------------------------------------------------------------
   // Read decoding
   // ----------------------------------------------------------------
   function automatic logic [7:0] read_reg(input logic [3:0] addr);
      logic [7:0] val;
      val = 8'h00;
      if (addr == gdfd_pkg::ADDR_GLOBAL) begin
         val = global_fault_flags;
      end else if (addr == gdfd_pkg::ADDR_TEST_CTRL) begin
         val[gdfd_pkg::CTRL_OPEN_LOAD] = open_pend || in_test(test_state, gdfd_pkg::TEST_OPEN_LOAD);
         val[gdfd_pkg::CTRL_SHORT] = short_pend || in_test(test_state, gdfd_pkg::TEST_SHORT);
      end else begin
         for (int p = 0; p < NUM_PHASES; p++) begin
            if (addr == gdfd_pkg::ADDR_PHASE1 + 4'(p)) begin
               val = diag[p];
            end
         end
      end
      return val;
   endfunction : read_reg

   // ----------------------------------------------------------------
   // Serial port edge detection
   // ----------------------------------------------------------------
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         sclk_q <= 1'b0;
         cs_q <= 1'b1;
      end else begin
         sclk_q <= i_spi_sclk;
         cs_q <= i_spi_cs_n;
      end
   end

   assign sclk_rise = !i_spi_cs_n && i_spi_sclk && !sclk_q;
   assign sclk_fall = !i_spi_cs_n && !i_spi_sclk && sclk_q;
   assign cs_fall = !i_spi_cs_n && cs_q;
   assign next_rx = {rx_shift[14:0], i_spi_mosi};

   // ----------------------------------------------------------------
   // Serial receive
   // ----------------------------------------------------------------
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         bit_cnt <= 5'h00;
         rx_shift <= 16'h0000;
      end else if (i_spi_cs_n) begin
         bit_cnt <= 5'h00;
      end else if (sclk_rise && bit_cnt != gdfd_pkg::FRAME_BITS) begin
         bit_cnt <= bit_cnt + 5'h01;
         rx_shift <= next_rx;
      end
   end

   assign frame_write = sclk_rise && bit_cnt == gdfd_pkg::FRAME_LAST_BIT && !next_rx[15]
      && next_rx[14:11] == gdfd_pkg::ADDR_TEST_CTRL;
   assign open_load_test_trigger = frame_write && next_rx[gdfd_pkg::CTRL_OPEN_LOAD];
   assign short_test_trigger = frame_write && next_rx[gdfd_pkg::CTRL_SHORT];
   assign clear_faults = frame_write && next_rx[gdfd_pkg::CTRL_CLEAR];

   // ----------------------------------------------------------------
   // Serial transmit
   // ----------------------------------------------------------------
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         status_cap <= 8'h00;
      end else if (cs_fall) begin
         status_cap <= global_fault_flags;
      end
   end

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         read_cap <= 8'h00;
      end else if (sclk_rise && bit_cnt == gdfd_pkg::HEADER_LAST_BIT) begin
         read_cap <= read_reg(next_rx[6:3]);
      end
   end

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_spi_miso <= 1'b0;
      end else if (cs_fall) begin
         o_spi_miso <= global_fault_flags[gdfd_pkg::GLB_SUMMARY];
      end else if (sclk_fall && bit_cnt < gdfd_pkg::HEADER_BITS) begin
         o_spi_miso <= status_cap[3'h7 - bit_cnt[2:0]];
      end else if (sclk_fall && bit_cnt < gdfd_pkg::FRAME_BITS) begin
         o_spi_miso <= read_cap[3'h7 - bit_cnt[2:0]];
      end
   end

   assign o_spi_miso_oe_n = i_spi_cs_n;

   // ----------------------------------------------------------------
   // Diagnostic test sequencer
   // ----------------------------------------------------------------
   assign test_start = in_test(test_state, gdfd_pkg::TEST_IDLE) && (open_pend || short_pend);
   assign timer_done = test_timer == 16'h0000;

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         open_pend <= 1'b0;
         short_pend <= 1'b0;
      end else begin
         open_pend <= (open_pend && !test_start) || open_load_test_trigger;
         short_pend <= (short_pend && !(test_start && !open_pend)) || short_test_trigger;
      end
   end

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         test_state <= gdfd_pkg::TEST_IDLE;
         test_timer <= 16'h0000;
      end else begin
         case (test_state)
            gdfd_pkg::TEST_IDLE: begin
               test_timer <= TEST_LOAD;
               if (open_pend) begin
                  test_state <= gdfd_pkg::TEST_OPEN_LOAD;
               end else if (short_pend) begin
                  test_state <= gdfd_pkg::TEST_SHORT;
               end
            end
            gdfd_pkg::TEST_OPEN_LOAD, gdfd_pkg::TEST_SHORT: begin
               if (timer_done) begin
                  test_state <= gdfd_pkg::TEST_IDLE;
               end else begin
                  test_timer <= test_timer - 16'h0001;
               end
            end
            default: begin
               test_state <= gdfd_pkg::TEST_IDLE;
            end
         endcase
      end
   end

   assign open_done = in_test(test_state, gdfd_pkg::TEST_OPEN_LOAD) && timer_done;
   assign short_done = in_test(test_state, gdfd_pkg::TEST_SHORT) && timer_done;
   assign o_open_load_test_active = in_test(test_state, gdfd_pkg::TEST_OPEN_LOAD);
   assign o_short_test_active = in_test(test_state, gdfd_pkg::TEST_SHORT);

   // ----------------------------------------------------------------
   // Global fault flags
   // ----------------------------------------------------------------
   assign live_set = {i_global_cond.gate_drive, i_global_cond.charge_pump_low,
      i_global_cond.supply_undervoltage, i_global_cond.overcurrent,
      i_global_cond.overtemp_warning, i_global_cond.overtemp_shutdown};

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         live_flags <= 6'h00;
      end else begin
         live_flags <= live_set | (clear_faults ? 6'h00 : live_flags);
      end
   end

   // ----------------------------------------------------------------
   // Phase diagnostic flags
   // ----------------------------------------------------------------
   for (genvar p = 0; p < NUM_PHASES; p++) begin : g_phase
      logic [7:0] phase_set;

      assign phase_set = {i_phase_cond[p].sense_overcurrent,
         short_done && i_phase_cond[p].at_ground,
         short_done && i_phase_cond[p].at_battery,
         open_done && i_phase_cond[p].load_open,
         i_phase_cond[p].low_gate_source, i_phase_cond[p].high_gate_source,
         i_phase_cond[p].low_drain_source, i_phase_cond[p].high_drain_source};

      always_ff @(posedge i_mclk or negedge i_rst_n) begin
         if (!i_rst_n) begin
            diag[p] <= gdfd_pkg::RESET_FLAGS;
         end else begin
            diag[p] <= phase_set | (clear_faults ? 8'h00 : diag[p]);
         end
      end

      assign phase_open_short[p] = |diag[p][gdfd_pkg::PH_GROUND_SHORT:gdfd_pkg::PH_OPEN_LOAD];
      assign phase_any[p] = |diag[p];
   end

   // ----------------------------------------------------------------
   // Summary and fault indication
   // ----------------------------------------------------------------
   assign open_or_short_summary_flag = |phase_open_short;
   assign fault_summary = (|live_flags) || (|phase_any);
   assign global_fault_flags = {fault_summary, live_flags, open_or_short_summary_flag};

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_fault_indication_n <= 1'b1;
      end else begin
         o_fault_indication_n <= !fault_summary;
      end
   end

endmodule : gdfd_fault_bank

// [tb/gdfd_props.sv]
// Port assertions for the fault bank
module gdfd_props #(parameter int NUM_PHASES = 3, parameter int TEST_CYCLES = 4) (
   input wire logic i_mclk,
   input wire logic i_rst_n,
   input wire logic i_spi_cs_n,
   input wire logic i_spi_sclk,
   input wire logic i_spi_mosi,
   input wire logic o_spi_miso,
   input wire logic o_spi_miso_oe_n,
   input wire gdfd_pkg::gdfd_global_s i_global_cond,
   input wire gdfd_pkg::gdfd_phase_s i_phase_cond [NUM_PHASES],
   input wire logic o_open_load_test_active,
   input wire logic o_short_test_active,
   input wire logic o_fault_indication_n
);
   timeunit 1ns;
   timeprecision 1ps;
   // ------
   // Helpers
   // ------
   logic live;
   logic opn;
   logic sht;
   int ol_n;
   int sh_n;
   always_comb begin
      live = 1'b0;
      opn = 1'b0;
      sht = 1'b0;
      for (int p = 0; p < NUM_PHASES; p++) begin
         live = live | (|(i_phase_cond[p] & 8'h8F));
         opn = opn | i_phase_cond[p].load_open;
         sht = sht | i_phase_cond[p].at_ground | i_phase_cond[p].at_battery;
      end
   end
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ol_n <= 0;
         sh_n <= 0;
      end else begin
         ol_n <= o_open_load_test_active ? ol_n + 1 : 0;
         sh_n <= o_short_test_active ? sh_n + 1 : 0;
      end
   end
   default clocking @(posedge i_mclk); endclocking
   default disable iff (!i_rst_n);
   a_oe_follows_cs: assert property (o_spi_miso_oe_n == i_spi_cs_n)
      else $error("output enable wrong");
   a_tests_exclusive: assert property (!(o_open_load_test_active && o_short_test_active))
      else $error("tests overlap");
   a_open_length: assert property ($fell(o_open_load_test_active) |-> ol_n == TEST_CYCLES)
      else $error("open test length");
   a_short_length: assert property ($fell(o_short_test_active) |-> sh_n == TEST_CYCLES)
      else $error("short test length");
   a_global_raise: assert property (|i_global_cond |-> ##[1:3] !o_fault_indication_n)
      else $error("global fault not shown");
   a_phase_raise: assert property (live |-> ##[1:3] !o_fault_indication_n)
      else $error("phase fault not shown");
   a_open_result: assert property ($fell(o_open_load_test_active) && $past(opn)
      |-> ##[0:2] !o_fault_indication_n) else $error("open load not shown");
   a_short_result: assert property ($fell(o_short_test_active) && $past(sht)
      |-> ##[0:2] !o_fault_indication_n) else $error("short not shown");
   a_miso_holds: assert property (i_spi_sclk && $past(i_spi_sclk) && !i_spi_cs_n
      |-> $stable(o_spi_miso)) else $error("miso moved while clock high");
   c_open_test: cover property ($fell(o_open_load_test_active));
   c_short_test: cover property ($fell(o_short_test_active));
   c_fault_low: cover property ($fell(o_fault_indication_n));
endmodule : gdfd_props

bind gdfd_fault_bank gdfd_props #(.NUM_PHASES(NUM_PHASES), .TEST_CYCLES(TEST_CYCLES)) props_u (
   .i_mclk, .i_rst_n, .i_spi_cs_n, .i_spi_sclk, .i_spi_mosi, .o_spi_miso, .o_spi_miso_oe_n,
   .i_global_cond, .i_phase_cond, .o_open_load_test_active, .o_short_test_active,
   .o_fault_indication_n);

// [tb/gdfd_host.sv]
// Serial host model sending register frames
module gdfd_host (
   input wire logic i_mclk,
   input wire logic i_miso,
   output logic o_cs_n,
   output logic o_sclk,
   output logic o_mosi
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      o_cs_n = 1'b1;
      o_sclk = 1'b0;
      o_mosi = 1'b0;
   end
   // ------
   // One frame, mode 0, MSB first
   // ------
   task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
      @(posedge i_mclk);
      o_cs_n <= 1'b0;
      for (int b = 15; b >= 0; b--) begin
         o_mosi <= tx[b];
         repeat (4) @(posedge i_mclk);
         rx[b] = i_miso;
         o_sclk <= 1'b1;
         repeat (4) @(posedge i_mclk);
         o_sclk <= 1'b0;
      end
      repeat (4) @(posedge i_mclk);
      o_cs_n <= 1'b1;
      repeat (4) @(posedge i_mclk);
   endtask : xfer
endmodule : gdfd_host

// [tb/gdfd_fault_bank_bench.sv]
// Self-checking bench for the fault bank
module gdfd_fault_bank_bench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int NP = 3;
   logic i_mclk = 1'b0;
   logic i_rst_n = 1'b0;
   logic cs_n, sclk, mosi, miso, oe_n, ol_act, sh_act, fault_n;
   gdfd_pkg::gdfd_global_s g = '0;
   gdfd_pkg::gdfd_phase_s ph [NP] = '{default: '0};
   int bad_count = 0;
   int samples_checked = 0;
   int cyc = 0;
   logic [1:0] ran = 2'b00;
   logic ran_clr = 1'b0;
   logic [15:0] rx;
   logic [7:0] eg;
   logic [7:0] ep [NP];
   gdfd_fault_bank #(.NUM_PHASES(NP), .TEST_CYCLES(4)) dut_u (.i_mclk(i_mclk),
      .i_rst_n(i_rst_n), .i_spi_cs_n(cs_n), .i_spi_sclk(sclk), .i_spi_mosi(mosi),
      .o_spi_miso(miso), .o_spi_miso_oe_n(oe_n), .i_global_cond(g), .i_phase_cond(ph),
      .o_open_load_test_active(ol_act), .o_short_test_active(sh_act),
      .o_fault_indication_n(fault_n));
   gdfd_host host_u (.i_mclk(i_mclk), .i_miso(miso), .o_cs_n(cs_n), .o_sclk(sclk),
      .o_mosi(mosi));
   // ------
   // Checks and bus tasks
   // ------
   task automatic close_out();
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : close_out
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic rd(input logic [3:0] a, input logic [7:0] exp);
      host_u.xfer({1'b1, a, 3'b000, 8'h00}, rx);
      chk(rx[15:8], eg);
      chk(rx[7:0], exp);
   endtask : rd
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      host_u.xfer({1'b0, a, 3'b000, d}, rx);
   endtask : wr
   task automatic clear_all();
      @(posedge i_mclk);
      g <= '0;
      ph <= '{default: '0};
      wr(4'h5, 8'h80);
      eg = 8'h00;
      chk({7'h0, fault_n}, 8'h01);
   endtask : clear_all
   function automatic logic [7:0] glb_of(input logic [5:0] c, input logic [7:0] a);
      return {(|c) | (|a), c, |a[6:4]};
   endfunction : glb_of
   always begin
      #5 i_mclk = ~i_mclk;
   end
   always @(posedge i_mclk) begin
      ran <= ran_clr ? 2'b00 : (ran | {sh_act, ol_act});
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         bad_count++;
         close_out();
      end
   end
   initial begin
      logic [5:0] c;
      logic [7:0] m;
      void'($urandom(32'hFB1A));
      repeat (10) @(posedge i_mclk);
      i_rst_n <= 1'b1;
      for (int i = 0; i < 10; i++) begin
         clear_all();
         @(posedge i_mclk);
         c = (i == 0) ? 6'h3F : (i == 1) ? 6'h08 : 6'($urandom);
         g <= c;
         for (int p = 0; p < NP; p++) begin
            ep[p] = (i == 0) ? 8'h8F : (i == 1) ? 8'h00 : 8'($urandom) & 8'h8F;
            ph[p] <= ep[p];
         end
         eg = glb_of(c, ep[0] | ep[1] | ep[2]);
         repeat (4) @(posedge i_mclk);
         g <= '0;
         ph <= '{default: '0};
         wr(4'h1, 8'hFF);
         rd(4'h0, eg);
         for (int p = 0; p < NP; p++) rd(4'(p + 1), ep[p]);
         rd(4'h7, 8'h00);
         rd(4'h5, 8'h00);
         chk({7'h0, fault_n}, {7'h0, ~eg[7]});
      end
      for (int k = 0; k < 3; k++) begin
         for (int p = 0; p < NP; p++) begin
            clear_all();
            m = (k == 0) ? 8'h10 : (k == 1) ? 8'h40 : 8'h20;
            ph[p] <= m;
            ran_clr <= 1'b1;
            @(posedge i_mclk);
            ran_clr <= 1'b0;
            wr(4'h5, (p == 2) ? 8'h03 : (k == 0) ? 8'h01 : 8'h02);
            for (int w = 0; w < 40 && (ol_act || sh_act || ran == 2'b00); w++) @(posedge i_mclk);
            chk({6'h0, ran}, (p == 2) ? 8'h03 : (k == 0) ? 8'h01 : 8'h02);
            eg = 8'h81;
            rd(4'(p + 1), m);
            chk({7'h0, fault_n}, 8'h00);
         end
      end
      close_out();
   end
endmodule : gdfd_fault_bank_bench
